// *** smsp_pkg.sv ***
package smsp_pkg;

  // ----------------------------------------------------------------
  // Register map (data-space offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h4c; // serial_port_control
  localparam logic [7:0] ADDR_STAT = 8'h4d; // serial_port_status
  localparam logic [7:0] ADDR_DATA = 8'h4e; // port_data_reg
  localparam logic [7:0] CTRL_RESET = 8'h00; // Control reset value
  localparam logic [7:0] DATA_RESET = 8'h00; // Data/shift reset value
  localparam logic [7:0] READ_ZERO = 8'h00; // Unmapped read value

  // ----------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------
  localparam int STAT_DONE_BIT = 7; // transfer_done
  localparam int STAT_WRITE_COLLISION_BIT = 6; // write_collision
  localparam int STAT_DSPEED_BIT = 0; // double_speed

  // ----------------------------------------------------------------
  // Transfer geometry
  // ----------------------------------------------------------------
  localparam logic [2:0] LAST_BIT = 3'h7; // Eighth bit of a byte
  localparam logic [3:0] LAST_EDGE = 4'hf; // Sixteenth SCK edge

  // ----------------------------------------------------------------
  // SCK half periods in system clocks
  // ----------------------------------------------------------------
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [6:0] HALF_DIV2 = 7'h01;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV32 = 7'h10;

  // Control register fields, bit 7 down to bit 0
  typedef struct packed {
    logic transfer_irq_en; // Bit 7
    logic port_enable; // Bit 6
    logic lsb_first; // Bit 5
    logic master_select; // Bit 4
    logic clock_polarity; // Bit 3
    logic clock_phase; // Bit 2
    logic rate_sel_hi; // Bit 1
    logic rate_sel_lo; // Bit 0
  } smsp_ctrl_s;

  // Driven side of a two-way pin
  typedef struct packed {
    logic out; // Level driven
    logic oe; // High while driving
  } smsp_pin_s;

  // Master sequencer states
  typedef enum logic [1:0] {
    MST_IDLE = 2'b01,
    MST_RUN = 2'b10
  } smsp_mst_e;

endpackage : smsp_pkg

// *** smsp_fifo.sv ***
`timescale 1ns/100ps
module smsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("smsp_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH]; // Entries
  logic [PW-1:0] wr_ptr_q; // Next write slot
  logic [PW-1:0] rd_ptr_q; // Oldest entry
  logic [PW:0] count_q; // Entries held
  logic push; // Accepted write
  logic pop; // Accepted read

  assign in_ready_o = (count_q < (PW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage write
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + PW'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + PW'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + (PW+1)'(1);
      end else if (pop && !push) begin
        count_q <= count_q - (PW+1)'(1);
      end
    end
  end

endmodule : smsp_fifo

// *** smsp_port.sv ***
`timescale 1ns/100ps
// Behaviour
// - slave: select input, low activates, MISO drives
// - slave select high resets counter, drops bits
// - master select output is plain general output
// - select low while master: become slave
// - mode fault also sets transfer-done flag
// - launch and sample on opposite SCK edges
// - polarity bit sets idle SCK level
// - phase bit picks leading or trailing sample
// - no serial operation unless enable bit set
// - order bit: one sends LSB first
// - master bit selects master or slave
// - rate bits divide clock, master only
// - interrupt when flag, enable, global enable
// - transfer-done set when each transfer ends
// - flag cleared by vector or read sequence
// - collision flag set on write while busy
// - collision sequence clears both flags
// - control register resets to zero
// - double speed halves master SCK period
// - data write starts; read gives buffer
// - single transmit buffer, buffered receive
// - exactly eight bits then stop, flag
module smsp_port
  import smsp_pkg::*;
#(
  parameter int RX_DEPTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic gie_i,
  input wire logic irq_ack_i,
  output logic irq_o,
  input wire logic ddr_sck_i,
  input wire logic ddr_mosi_i,
  input wire logic ddr_miso_i,
  input wire logic ddr_ss_i,
  input wire logic ss_val_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic ss_n_i,
  output smsp_pkg::smsp_pin_s sck_o,
  output smsp_pkg::smsp_pin_s mosi_o,
  output smsp_pkg::smsp_pin_s miso_o,
  output smsp_pkg::smsp_pin_s ss_n_o
);

  import smsp_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (RX_DEPTH < 2) begin : g_bad_rx
    $error("smsp_port receive buffer needs at least two entries");
  end

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Bit presented on the line
  function automatic logic head_bit(input logic [7:0] d, input logic lsb);
    head_bit = lsb ? d[0] : d[7];
  endfunction : head_bit

  // Shift one received bit in
  function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b,
                                          input logic lsb);
    shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
  endfunction : shift_in

  // SCK half period for a rate setting
  function automatic logic [6:0] half_period(input logic dbl, input logic [1:0] rate);
    case ({dbl, rate})
      3'h0: half_period = HALF_DIV4;
      3'h1: half_period = HALF_DIV16;
      3'h2: half_period = HALF_DIV64;
      3'h3: half_period = HALF_DIV128;
      3'h4: half_period = HALF_DIV2;
      3'h5: half_period = HALF_DIV8;
      3'h6: half_period = HALF_DIV32;
      default: half_period = HALF_DIV64;
    endcase
  endfunction : half_period

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  smsp_ctrl_s ctrl_q; // Control register
  logic dspeed_q; // Double speed bit
  logic done_q; // Transfer-done flag
  logic write_collision_q; // Write-collision flag
  logic done_arm_q; // Status read saw done
  logic write_collision_arm_q; // Status read saw collision
  logic [2:0] sck_sync_q; // SCK synchroniser and edge tap
  logic [1:0] mosi_sync_q; // MOSI synchroniser
  logic [1:0] miso_sync_q; // MISO synchroniser
  logic [1:0] ss_sync_q; // Select synchroniser
  smsp_mst_e mst_q; // Master sequencer state
  logic [6:0] half_cnt_q; // Half-period counter
  logic [3:0] edge_idx_q; // Master SCK edge index
  logic sck_lvl_q; // Master SCK level
  logic start_pend_q; // Master start waiting for room
  logic [7:0] shift_q; // Shift register
  logic [2:0] bit_cnt_q; // Bits sampled
  logic out_bit_q; // Bit on the output line
  logic [7:0] last_rx_q; // Last byte read out
  logic ss_low; // Synchronised select low
  logic is_master; // Enabled master
  logic is_slave; // Enabled slave
  logic slave_act; // Slave selected
  logic mode_fault; // Select low while master
  logic m_edge; // Master SCK edge this cycle
  logic lead_ev; // Leading SCK edge
  logic trail_ev; // Trailing SCK edge
  logic sample_ev; // Sampling edge
  logic setup_ev; // Launch edge
  logic din; // Incoming data bit
  logic xfer_done; // Eighth bit sampled
  logic byte_end; // Byte finished, flag it
  logic busy; // Transfer in progress
  logic data_wr; // Data register write
  logic data_rd; // Data register read
  logic stat_rd; // Status register read
  logic rx_ready; // Receive buffer has room
  logic rx_valid; // Receive buffer holds a byte
  logic [7:0] rx_head; // Oldest received byte
  logic clr_done; // Read sequence clears done
  logic clr_write_collision; // Read sequence clears collision

  // ----------------------------------------------------------------
  // Decode and mode
  // ----------------------------------------------------------------
  assign data_wr = io_wr_i && (io_addr_i == ADDR_DATA);
  assign data_rd = io_rd_i && (io_addr_i == ADDR_DATA);
  assign stat_rd = io_rd_i && (io_addr_i == ADDR_STAT);
  assign ss_low = !ss_sync_q[1];
  assign is_master = ctrl_q.port_enable && ctrl_q.master_select;
  assign is_slave = ctrl_q.port_enable && !ctrl_q.master_select;
  assign slave_act = is_slave && ss_low;
  assign mode_fault = is_master && !ddr_ss_i && ss_low;

  // ----------------------------------------------------------------
  // Edge events
  // ----------------------------------------------------------------
  assign m_edge = (mst_q == MST_RUN) && (half_cnt_q ==
                  half_period(dspeed_q, {ctrl_q.rate_sel_hi, ctrl_q.rate_sel_lo}) - 7'h01);
  // Slave edges: leading edge leaves the idle level
  assign lead_ev = is_master ? (m_edge && !edge_idx_q[0])
                 : (slave_act && (sck_sync_q[1] != sck_sync_q[2])
                    && (sck_sync_q[1] != ctrl_q.clock_polarity));
  assign trail_ev = is_master ? (m_edge && edge_idx_q[0])
                  : (slave_act && (sck_sync_q[1] != sck_sync_q[2])
                     && (sck_sync_q[1] == ctrl_q.clock_polarity));
  assign sample_ev = ctrl_q.clock_phase ? trail_ev : lead_ev;
  assign setup_ev = ctrl_q.clock_phase ? lead_ev : trail_ev;
  assign din = is_master ? miso_sync_q[1] : mosi_sync_q[1];
  assign xfer_done = sample_ev && (bit_cnt_q == LAST_BIT);
  // Master flags only once SCK is back at idle
  assign byte_end = is_master ? (m_edge && edge_idx_q == LAST_EDGE) : xfer_done;
  assign busy = (mst_q == MST_RUN) || start_pend_q || (slave_act && bit_cnt_q != 3'h0);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sck_sync_q <= 3'h0;
      mosi_sync_q <= 2'h0;
      miso_sync_q <= 2'h0;
      ss_sync_q <= 2'h3;
    end else begin
      sck_sync_q <= {sck_sync_q[1:0], sck_i};
      mosi_sync_q <= {mosi_sync_q[0], mosi_i};
      miso_sync_q <= {miso_sync_q[0], miso_i};
      ss_sync_q <= {ss_sync_q[0], ss_n_i};
    end
  end

  // ----------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------
  // Control register, mode fault wins over a write
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ctrl_q <= smsp_ctrl_s'(CTRL_RESET);
      dspeed_q <= 1'b0;
    end else begin
      if (io_wr_i && io_addr_i == ADDR_CTRL) begin
        ctrl_q <= smsp_ctrl_s'(io_wdata_i);
      end
      if (io_wr_i && io_addr_i == ADDR_STAT) begin
        dspeed_q <= io_wdata_i[STAT_DSPEED_BIT];
      end
      if (mode_fault) begin
        ctrl_q.master_select <= 1'b0;
      end
    end
  end

  // Clear sequence: status read, then data access
  assign clr_done = (data_rd || data_wr) && (done_arm_q || write_collision_arm_q);
  assign clr_write_collision = (data_rd || data_wr) && write_collision_arm_q;

  // Arming by a status read
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      done_arm_q <= 1'b0;
      write_collision_arm_q <= 1'b0;
    end else if (stat_rd) begin
      done_arm_q <= done_q;
      write_collision_arm_q <= write_collision_q;
    end else if (data_rd || data_wr) begin
      done_arm_q <= 1'b0;
      write_collision_arm_q <= 1'b0;
    end
  end

  // Flags, a new event wins over any clear
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      done_q <= 1'b0;
      write_collision_q <= 1'b0;
    end else begin
      done_q <= byte_end || mode_fault
             || (done_q && !clr_done && !irq_ack_i);
      write_collision_q <= (data_wr && busy) || (write_collision_q && !clr_write_collision);
    end
  end

  // Interrupt request
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= done_q && ctrl_q.transfer_irq_en && gie_i;
    end
  end

  // ----------------------------------------------------------------
  // Master clock sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mst_q <= MST_IDLE;
      half_cnt_q <= 7'h00;
      edge_idx_q <= 4'h0;
      sck_lvl_q <= 1'b0;
      start_pend_q <= 1'b0;
    end else if (!is_master || mode_fault) begin
      mst_q <= MST_IDLE;
      start_pend_q <= 1'b0;
      sck_lvl_q <= ctrl_q.clock_polarity;
    end else begin
      case (mst_q)
        MST_IDLE: begin
          sck_lvl_q <= ctrl_q.clock_polarity;
          if (data_wr && !busy) begin
            start_pend_q <= 1'b1;
          end else if (start_pend_q && rx_ready) begin
            start_pend_q <= 1'b0;
            mst_q <= MST_RUN;
            half_cnt_q <= 7'h00;
            edge_idx_q <= 4'h0;
          end
        end
        MST_RUN: begin
          if (m_edge) begin
            half_cnt_q <= 7'h00;
            sck_lvl_q <= !sck_lvl_q;
            edge_idx_q <= edge_idx_q + 4'h1;
            if (edge_idx_q == LAST_EDGE) begin
              mst_q <= MST_IDLE;
            end
          end else begin
            half_cnt_q <= half_cnt_q + 7'h01;
          end
        end
        default: begin
          mst_q <= MST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      shift_q <= DATA_RESET;
      bit_cnt_q <= 3'h0;
      out_bit_q <= 1'b0;
    end else if (!ctrl_q.port_enable || mode_fault || (is_slave && !ss_low)) begin
      bit_cnt_q <= 3'h0;
      if (data_wr) begin
        shift_q <= io_wdata_i;
      end
      if (is_slave) begin
        out_bit_q <= head_bit(data_wr ? io_wdata_i : shift_q, ctrl_q.lsb_first);
      end
    end else if (data_wr && !busy) begin
      shift_q <= io_wdata_i;
      out_bit_q <= head_bit(io_wdata_i, ctrl_q.lsb_first);
    end else begin
      if (sample_ev) begin
        shift_q <= shift_in(shift_q, din, ctrl_q.lsb_first);
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      if (setup_ev) begin
        out_bit_q <= head_bit(shift_q, ctrl_q.lsb_first);
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  smsp_fifo #(
    .WIDTH(8),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_valid_i(xfer_done),
    .in_ready_o(rx_ready),
    .in_data_i(shift_in(shift_q, din, ctrl_q.lsb_first)),
    .out_valid_o(rx_valid),
    .out_ready_i(data_rd),
    .out_data_o(rx_head)
  );

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      io_rdata_o <= READ_ZERO;
      last_rx_q <= DATA_RESET;
    end else if (io_rd_i) begin
      case (io_addr_i)
        ADDR_CTRL: io_rdata_o <= ctrl_q;
        ADDR_STAT: begin
          io_rdata_o <= READ_ZERO;
          io_rdata_o[STAT_DONE_BIT] <= done_q;
          io_rdata_o[STAT_WRITE_COLLISION_BIT] <= write_collision_q;
          io_rdata_o[STAT_DSPEED_BIT] <= dspeed_q;
        end
        ADDR_DATA: begin
          io_rdata_o <= rx_valid ? rx_head : last_rx_q;
          if (rx_valid) begin
            last_rx_q <= rx_head;
          end
        end
        default: io_rdata_o <= READ_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sck_o <= '0;
      mosi_o <= '0;
      miso_o <= '0;
      ss_n_o <= '0;
    end else begin
      sck_o.out <= (mst_q == MST_RUN) ? sck_lvl_q : ctrl_q.clock_polarity;
      sck_o.oe <= is_master && !mode_fault && ddr_sck_i;
      mosi_o.out <= out_bit_q;
      mosi_o.oe <= is_master && !mode_fault && ddr_mosi_i;
      miso_o.out <= out_bit_q;
      miso_o.oe <= slave_act && ddr_miso_i;
      ss_n_o.out <= ss_val_i;
      ss_n_o.oe <= ddr_ss_i && !is_slave;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_fault_demotes;
    @(posedge sys_clk_i) disable iff (reset_i)
      mode_fault |=> !ctrl_q.master_select ##1 (!sck_o.oe && !mosi_o.oe);
  endproperty
  a_fault_demotes: assert property (p_fault_demotes)
    else $error("mode fault did not demote to slave");

  property p_fault_flag;
    @(posedge sys_clk_i) disable iff (reset_i)
      mode_fault |=> done_q;
  endproperty
  a_fault_flag: assert property (p_fault_flag)
    else $error("mode fault did not set done flag");

  property p_ss_reset;
    @(posedge sys_clk_i) disable iff (reset_i)
      (is_slave && !ss_low) |=> (bit_cnt_q == 3'h0);
  endproperty
  a_ss_reset: assert property (p_ss_reset)
    else $error("bit counter not cleared while deselected");

  property p_disabled_quiet;
    @(posedge sys_clk_i) disable iff (reset_i)
      !ctrl_q.port_enable |=> (mst_q == MST_IDLE) && !miso_o.oe && !sck_o.oe;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("serial activity while disabled");

  property p_done_on_byte;
    @(posedge sys_clk_i) disable iff (reset_i)
      byte_end |=> done_q;
  endproperty
  a_done_on_byte: assert property (p_done_on_byte)
    else $error("done flag not set after eighth bit");

  property p_collision;
    @(posedge sys_clk_i) disable iff (reset_i)
      (data_wr && (mst_q == MST_RUN)) |=> write_collision_q && $stable(shift_q);
  endproperty
  a_collision: assert property (p_collision)
    else $error("write during transfer not flagged");

  property p_irq;
    @(posedge sys_clk_i) disable iff (reset_i)
      (done_q && ctrl_q.transfer_irq_en && gie_i) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");

  property p_vector_clear;
    @(posedge sys_clk_i) disable iff (reset_i)
      (irq_ack_i && !xfer_done && !mode_fault) |=> !done_q;
  endproperty
  a_vector_clear: assert property (p_vector_clear)
    else $error("vector did not clear done flag");

  property p_idle_sck;
    @(posedge sys_clk_i) disable iff (reset_i)
      (mst_q == MST_IDLE && $past(mst_q) == MST_IDLE) |=> sck_o.out == $past(ctrl_q.clock_polarity);
  endproperty
  a_idle_sck: assert property (p_idle_sck)
    else $error("SCK not at idle level between transfers");

  property p_sixteen_edges;
    @(posedge sys_clk_i) disable iff (reset_i)
      (m_edge && edge_idx_q == LAST_EDGE && !mode_fault && is_master) |=> (mst_q == MST_IDLE);
  endproperty
  a_sixteen_edges: assert property (p_sixteen_edges)
    else $error("master did not stop after last edge");

endmodule : smsp_port

// *** smsp_slave_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Far-side slave on the serial link
// ----------------------------------------------------------------
module smsp_slave_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic ss_n_i,
  input wire logic clock_polarity_i,
  input wire logic clock_phase_i,
  input wire logic lsb_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  int n_out = 0; // Bits launched
  int n_in = 0; // Bits sampled
  logic cur = 1'b0; // Bit on the line
  // Bit k of the byte in the chosen order
  function automatic logic pick(input int k);
    return lsb_i ? tx_i[k] : tx_i[7 - k];
  endfunction : pick
  // Frame start; first bit ready for a leading sample
  always @(negedge ss_n_i) begin
    n_in = 0;
    n_out = clock_phase_i ? 0 : 1;
    cur = pick(0);
  end
  // Sample on one edge, launch on the other
  always @(sck_i) begin
    if (!ss_n_i && n_in < 8) begin
      if (sck_i == (clock_polarity_i == clock_phase_i)) begin
        rx_o[lsb_i ? n_in : 7 - n_in] = mosi_i;
        n_in++;
      end else if (n_out < 8) begin
        cur = pick(n_out);
        n_out++;
      end
    end
  end
  // Released line shows the inverse of its last bit
  assign miso_o = ss_n_i ? ~cur : cur;
endmodule : smsp_slave_model

// *** testbench.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Self-checking bench for the serial port
// ----------------------------------------------------------------
module testbench;
  import smsp_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, gie = 1'b0, ack = 1'b0;
  logic ss_ext = 1'b1, ss_val = 1'b1, ddr_ss = 1'b1, ddr_miso = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, tx = 8'h00, rx, v, d;
  logic irq, miso;
  smsp_ctrl_s cfg = '0; // Settings the slave follows
  smsp_pin_s sck_p, mosi_p, miso_p, ss_p;
  wire sck_w = sck_p.oe ? sck_p.out : ~sck_p.out;
  wire mosi_w = mosi_p.oe ? mosi_p.out : ~mosi_p.out;
  wire ss_w = ss_p.oe ? ss_p.out : 1'b1; // Pull-up
  int bad_count = 0, n_tests = 0, cyc = 0, k, c0;
  smsp_port u_dut (.sys_clk_i(sys_clk), .reset_i(rst), .io_addr_i(addr), .io_wr_i(wr),
    .io_rd_i(rd), .io_wdata_i(wdata), .io_rdata_o(rdata), .gie_i(gie), .irq_ack_i(ack),
    .irq_o(irq), .ddr_sck_i(1'b1), .ddr_mosi_i(1'b1), .ddr_miso_i(ddr_miso), .ddr_ss_i(ddr_ss),
    .ss_val_i(ss_val), .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso), .ss_n_i(ss_ext),
    .sck_o(sck_p), .mosi_o(mosi_p), .miso_o(miso_p), .ss_n_o(ss_p));
  smsp_slave_model u_slave (.sck_i(sck_w), .mosi_i(mosi_w), .ss_n_i(ss_w),
    .clock_polarity_i(cfg.clock_polarity), .clock_phase_i(cfg.clock_phase), .lsb_i(cfg.lsb_first),
    .tx_i(tx), .miso_o(miso), .rx_o(rx));
  initial forever #2.5 sys_clk = ~sys_clk;
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      print_verdict();
    end
  end
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One register cycle; read data lands in v
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dat);
    @(posedge sys_clk);
    #1 addr = a;
    wdata = dat;
    wr = w;
    rd = !w;
    @(posedge sys_clk);
    #1 wr = 1'b0;
    rd = 1'b0;
    v = rdata;
  endtask : acc
  // Poll status until the done flag shows
  task automatic wait_done;
    v = 8'h00;
    for (int n = 0; n < 600 && !v[7]; n++) acc(1'b0, ADDR_STAT, 8'h00);
  endtask : wait_done
  // SCK half period in system clocks for a rate setting
  function automatic int half_of(input logic dbl, input logic [1:0] r);
    return ((r == 2'h3) ? 64 : (2 << (2 * r))) >> dbl;
  endfunction : half_of
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    void'($urandom(32'h66cf));
    repeat (12) @(posedge sys_clk);
    #1 rst = 1'b0;
    acc(1'b0, ADDR_CTRL, 8'h00); chk(v, CTRL_RESET);
    acc(1'b0, ADDR_STAT, 8'h00); chk(v, 8'h00);
    acc(1'b0, 8'h50, 8'h00); chk(v, READ_ZERO);
    acc(1'b1, ADDR_CTRL, 8'h11);
    acc(1'b1, ADDR_DATA, 8'ha5);
    repeat (200) @(posedge sys_clk);
    acc(1'b0, ADDR_STAT, 8'h00); chk(v, 8'h00);
    chk({7'h0, sck_p.oe}, 8'h00);
    $display("test reset and disable done");
    // Every mode in both bit orders, random bytes except the first sent, 8'h01
    for (int i = 0; i < 8; i++) begin
      cfg = {2'b01, i[2], 1'b1, i[1], i[0], 2'(1 + $urandom % 3)};
      tx = 8'($urandom);
      d = (i == 0) ? 8'h01 : 8'($urandom);
      acc(1'b1, ADDR_STAT, {7'h0, i[0] ^ i[1]});
      acc(1'b1, ADDR_CTRL, cfg);
      @(posedge sys_clk);
      #1 ss_val = 1'b0;
      acc(1'b1, ADDR_DATA, d);
      c0 = cyc;
      wait_done(); chk(v & 8'h80, 8'h80);
      k = 16 * half_of(i[0] ^ i[1], {cfg.rate_sel_hi, cfg.rate_sel_lo}) + 2;
      chk({7'h0, cyc - c0 == k}, 8'h01);
      acc(1'b0, ADDR_DATA, 8'h00); chk(v, tx);
      chk(rx, d);
      chk({7'h0, sck_w}, {7'h0, cfg.clock_polarity});
      acc(1'b0, ADDR_STAT, 8'h00); chk(v, {7'h0, i[0] ^ i[1]});
      ss_val = 1'b1;
    end
    $display("test modes done");
    d = 8'($urandom);
    @(posedge sys_clk);
    #1 ss_val = 1'b0;
    acc(1'b1, ADDR_DATA, d);
    acc(1'b1, ADDR_DATA, ~d);
    wait_done(); chk(v, 8'hc0);
    chk(rx, d);
    acc(1'b0, ADDR_DATA, 8'h00); chk(v, tx);
    acc(1'b0, ADDR_STAT, 8'h00); chk(v, 8'h00);
    ss_val = 1'b1;
    $display("test collision done");
    cfg = 8'hd1;
    gie = 1'b1;
    acc(1'b1, ADDR_CTRL, cfg);
    @(posedge sys_clk);
    #1 ss_val = 1'b0;
    acc(1'b1, ADDR_DATA, d);
    for (k = 0; k < 400 && irq !== 1'b1; k++) @(posedge sys_clk);
    #1 chk({7'h0, irq}, 8'h01);
    ack = 1'b1;
    @(posedge sys_clk);
    #1 ack = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk({7'h0, irq}, 8'h00);
    acc(1'b0, ADDR_STAT, 8'h00); chk(v, 8'h00);
    ss_val = 1'b1;
    $display("test interrupt done");
    ddr_ss = 1'b0;
    ss_ext = 1'b0;
    repeat (4) @(posedge sys_clk);
    acc(1'b0, ADDR_CTRL, 8'h00); chk(v, 8'hc1);
    chk({6'h0, sck_p.oe, mosi_p.oe}, 8'h00);
    chk({7'h0, miso_p.oe}, 8'h01);
    acc(1'b0, ADDR_STAT, 8'h00); chk(v & 8'h80, 8'h80);
    ss_ext = 1'b1;
    acc(1'b0, ADDR_DATA, 8'h00);
    acc(1'b1, ADDR_CTRL, 8'h51);
    chk({7'h0, miso_p.oe}, 8'h00);
    acc(1'b0, ADDR_CTRL, 8'h00); chk(v, 8'h51);
    ddr_ss = 1'b1;
    $display("test mode fault done");
    print_verdict();
  end
endmodule : testbench
